// ### core/ilt_pkg.sv
/*
  Constants and types for the instruction length and timing calculator.
  Assumes it is compiled ahead of every file in core/.
*/
package ilt_pkg;

  // Output widths
  localparam int LEN_W = 4;   // Instruction length in bytes
  localparam int CYC_W = 20;  // Cycle count, wide enough for 64K transfers

  // Length adjustment
  localparam logic [LEN_W-1:0] LEN_EXTRA = 4'h1;

  // Cycle adjustments
  localparam logic [CYC_W-1:0] DP_EXTRA     = 20'h00001;
  localparam logic [CYC_W-1:0] TAKEN_EXTRA  = 20'h00002;
  localparam logic [CYC_W-1:0] DIV_EXTRA    = 20'h00010;
  localparam logic [CYC_W-1:0] MUL_EXTRA    = 20'h00008;

  // Multi-register push
  localparam logic [CYC_W-1:0] PUSH_BASE    = 20'h0000C;
  localparam logic [CYC_W-1:0] PUSH_WORD    = 20'h00002;
  localparam logic [CYC_W-1:0] PUSH_BANK    = 20'h00001;

  // Multi-register pull
  localparam logic [CYC_W-1:0] PULL_BASE    = 20'h0000E;
  localparam logic [CYC_W-1:0] PULL_REG     = 20'h00003;
  localparam logic [CYC_W-1:0] PULL_DP      = 20'h00004;

  // Block transfer, odd byte count
  localparam logic [CYC_W-1:0] BLK_PAIR     = 20'h00007;
  localparam logic [CYC_W-1:0] BLK1_HEAD    = 20'h00007;
  localparam logic [CYC_W-1:0] BLK1_TAIL    = 20'h00004;
  localparam logic [CYC_W-1:0] BLK2_HEAD    = 20'h00009;
  localparam logic [CYC_W-1:0] BLK2_TAIL    = 20'h00005;

  // Bit positions of the register list
  localparam int RL_A  = 0;
  localparam int RL_B  = 1;
  localparam int RL_X  = 2;
  localparam int RL_Y  = 3;
  localparam int RL_DP = 4;  // direct_page_base
  localparam int RL_DB = 5;  // data_bank_reg
  localparam int RL_PB = 6;  // program_bank_reg
  localparam int RL_PS = 7;  // processor_status_reg

  // Instruction classes that change length or timing
  typedef enum logic [3:0] {
    CLS_PLAIN,     // No adjustment beyond direct page
    CLS_IMM_M,     // Immediate, operand width from m
    CLS_IMM_X,     // Immediate, operand width from x
    CLS_MDEP,      // Byte count grows when m is cleared
    CLS_BRANCH,    // Conditional relative branch
    CLS_PUSH,      // Multi-register push
    CLS_PULL,      // Multi-register pull
    CLS_BLK1,      // First block transfer form
    CLS_BLK2,      // Second block transfer form
    CLS_DIV,       // Divide
    CLS_MUL        // Multiply
  } instr_class_t;

endpackage

// ### core/stack_cycle_calc.sv
/*
  Cycle count of the multi-register push and pull instructions.
  Purely combinational; the register list is one bit per register.
*/
`timescale 1ns/1ps
module stack_cycle_calc
  import ilt_pkg::*;
(
  input  wire logic [7:0]       reg_list,   // Registers selected
  output logic      [CYC_W-1:0] push_cyc,   // Push cycle total
  output logic      [CYC_W-1:0] pull_cyc    // Pull cycle total
);

  // Each selected register adds its own share to the base count
  always_comb begin
    push_cyc = PUSH_BASE;
    pull_cyc = PULL_BASE;
    for (int k = 0; k < 8; k++) begin
      if (reg_list[k]) begin
        // Bank registers are single bytes on the stack
        if (k == RL_DB || k == RL_PB) begin
          push_cyc = push_cyc + PUSH_BANK;
        end else begin
          push_cyc = push_cyc + PUSH_WORD;
        end
        // Program bank cannot be pulled; direct page costs more
        if (k == RL_DP) begin
          pull_cyc = pull_cyc + PULL_DP;
        end else if (k != RL_PB) begin
          pull_cyc = pull_cyc + PULL_REG;
        end
      end
    end
  end

endmodule

// ### core/block_xfer_calc.sv
/*
  Cycle count of the two block transfer forms for an odd byte count.
  Purely combinational; the caller selects it only for odd counts.
*/
`timescale 1ns/1ps
module block_xfer_calc
  import ilt_pkg::*;
(
  input  wire logic [15:0]      xfer_count,  // Bytes to move
  output logic      [CYC_W-1:0] blk1_cyc,    // First form, odd count
  output logic      [CYC_W-1:0] blk2_cyc     // Second form, odd count
);

  logic [CYC_W-1:0] pairs;      // Integer part of count / 2
  logic [CYC_W-1:0] pair_cyc;   // Seven cycles per byte pair

  assign pairs    = {5'h00, xfer_count[15:1]};
  assign pair_cyc = CYC_W'(pairs * BLK_PAIR);

  assign blk1_cyc = BLK1_HEAD + pair_cyc + BLK1_TAIL;
  assign blk2_cyc = BLK2_HEAD + pair_cyc + BLK2_TAIL;

endmodule

// ### core/cpu_instruction_length_timing.sv
/*
  Instruction length and fastest-mode cycle calculator for a 16-bit core.
  The caller supplies the listed length and cycle count from its own
  instruction table, the instruction class and the run-time conditions;
  one clock later the adjusted figures appear with a one-cycle strobe.
  All inputs except BUS_BYTE_PIN and ARST_N come from logic on CLK.
*/
// Functional notes
// - Nonzero direct page low byte adds one cycle
// - Upper opcode row is A, lower B
// - Immediate with 16-bit data: one byte more
// - Taken conditional branch adds two cycles
// - Short branch form if displacement fits byte
// - Data-length dependent: one byte more if m=0
// - Push: 12 base, 2 per word, 1 bank
// - Pull: 14 base, 3 each, 4 direct page
// - First block form odd: 7+7*(i/2)+4
// - Second block form odd: 9+7*(i/2)+5
// - Wide divide adds sixteen cycles
// - Wide multiply adds eight cycles
// - Immediate with 16-bit index: one byte more
// - Real counts may exceed the fastest figures
`timescale 1ns/1ps
module cpu_instruction_length_timing
  import ilt_pkg::*;
(
  input  wire logic               CLK,
  input  wire logic               ARST_N,
  input  wire logic               REQ_VALID,
  input  wire instr_class_t       INSTR_CLASS,
  input  wire logic [LEN_W-1:0]   LISTED_LEN,
  input  wire logic [CYC_W-1:0]   LISTED_CYC,
  input  wire logic               OPCODE_LOWER_ROW,
  input  wire logic               USES_DIRECT_PAGE,
  input  wire logic [7:0]         DIRECT_PAGE_BASE_LOW,
  input  wire logic               M_FLAG,
  input  wire logic               X_FLAG,
  input  wire logic               BRANCH_TAKEN,
  input  wire logic [15:0]        BRANCH_DISP,
  input  wire logic [7:0]         REG_LIST,
  input  wire logic [15:0]        XFER_COUNT,
  input  wire logic               WIDE_OPERATION,
  input  wire logic               ODD_OPERAND_ADDR,
  input  wire logic               BUS_BYTE_PIN,
  output logic                    OUT_VALID,
  output logic      [LEN_W-1:0]   INSTR_LEN,
  output logic      [CYC_W-1:0]   INSTR_CYC,
  output logic                    ACC_B_SEL,
  output logic                    BRANCH_LONG,
  output logic                    CYC_MAY_EXCEED
);

  // Reset release synchroniser
  logic rst_meta_q;   // First stage, read only by the second
  logic rst_n_q;      // Released reset used by all other logic

  // Bus width pin synchroniser
  logic byte_meta_q;  // First stage, read only by the second
  logic byte_q;       // Synchronised bus width level

  // Output registers
  logic             valid_q;
  logic             valid_d;
  logic [LEN_W-1:0] len_q;
  logic [LEN_W-1:0] len_d;
  logic [CYC_W-1:0] cyc_q;
  logic [CYC_W-1:0] cyc_d;
  logic             acc_b_q;
  logic             acc_b_d;
  logic             long_q;
  logic             long_d;
  logic             exceed_q;
  logic             exceed_d;

  // Helper results
  logic [CYC_W-1:0] push_cyc;   // Multi-register push total
  logic [CYC_W-1:0] pull_cyc;   // Multi-register pull total
  logic [CYC_W-1:0] blk1_cyc;   // First block form, odd count
  logic [CYC_W-1:0] blk2_cyc;   // Second block form, odd count

  // Decoded conditions
  wire dp_extra_w;              // Direct page base misaligned
  wire imm_m_w;                 // 16-bit immediate data
  wire imm_x_w;                 // 16-bit immediate index
  wire mdep_w;                  // Data-length dependent byte
  wire taken_w;                 // Conditional branch goes
  wire short_fit_w;             // Displacement fits a byte
  wire blk_odd_w;               // Odd byte count
  wire div_wide_w;              // 32 by 16 divide
  wire mul_wide_w;              // 16 by 16 multiply

  // Adjustment terms
  wire [LEN_W-1:0] len_add_w;   // Bytes added to the listed length
  wire [CYC_W-1:0] base_cyc_w;  // Listed or replaced cycle figure
  wire [CYC_W-1:0] cyc_add_w;   // Cycles added on top

  // Reset is asserted at once and released after two edges
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // The width pin is asynchronous to CLK
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      byte_meta_q <= 1'b0;
      byte_q      <= 1'b0;
    end else begin
      byte_meta_q <= BUS_BYTE_PIN;
      byte_q      <= byte_meta_q;
    end
  end

  // Push and pull cycle totals
  stack_cycle_calc u_stack (
    .reg_list (REG_LIST),
    .push_cyc (push_cyc),
    .pull_cyc (pull_cyc)
  );

  // Odd-count block transfer totals
  block_xfer_calc u_block (
    .xfer_count (XFER_COUNT),
    .blk1_cyc   (blk1_cyc),
    .blk2_cyc   (blk2_cyc)
  );

  // Condition decode
  assign dp_extra_w  = USES_DIRECT_PAGE &&
                       (DIRECT_PAGE_BASE_LOW != 8'h00);
  assign imm_m_w     = (INSTR_CLASS == CLS_IMM_M) && !M_FLAG;
  assign imm_x_w     = (INSTR_CLASS == CLS_IMM_X) && !X_FLAG;
  assign mdep_w      = (INSTR_CLASS == CLS_MDEP) && !M_FLAG;
  assign taken_w     = (INSTR_CLASS == CLS_BRANCH) && BRANCH_TAKEN;
  // A byte displacement has its top nine bits all equal
  assign short_fit_w = (BRANCH_DISP[15:7] == 9'h000) ||
                       (BRANCH_DISP[15:7] == 9'h1FF);
  assign blk_odd_w   = XFER_COUNT[0];
  assign div_wide_w  = (INSTR_CLASS == CLS_DIV) && WIDE_OPERATION;
  assign mul_wide_w  = (INSTR_CLASS == CLS_MUL) && WIDE_OPERATION;

  // Length: at most one of the byte growth terms applies per class
  assign len_add_w = (imm_m_w || imm_x_w || mdep_w) ? LEN_EXTRA
                                                    : {LEN_W{1'b0}};

  // Stack and odd block forms replace the listed figure outright
  assign base_cyc_w =
    (INSTR_CLASS == CLS_PUSH)              ? push_cyc :
    (INSTR_CLASS == CLS_PULL)              ? pull_cyc :
    (INSTR_CLASS == CLS_BLK1 && blk_odd_w) ? blk1_cyc :
    (INSTR_CLASS == CLS_BLK2 && blk_odd_w) ? blk2_cyc :
                                             LISTED_CYC;

  // Additive terms are independent, so they simply sum
  assign cyc_add_w = (dp_extra_w ? DP_EXTRA    : {CYC_W{1'b0}})
                   + (taken_w    ? TAKEN_EXTRA : {CYC_W{1'b0}})
                   + (div_wide_w ? DIV_EXTRA   : {CYC_W{1'b0}})
                   + (mul_wide_w ? MUL_EXTRA   : {CYC_W{1'b0}});

  // Next output values; results hold until the next request
  always_comb begin
    valid_d  = REQ_VALID;
    len_d    = len_q;
    cyc_d    = cyc_q;
    acc_b_d  = acc_b_q;
    long_d   = long_q;
    exceed_d = exceed_q;
    if (REQ_VALID) begin
      len_d    = LISTED_LEN + len_add_w;
      cyc_d    = base_cyc_w + cyc_add_w;
      acc_b_d  = OPCODE_LOWER_ROW;
      long_d   = (INSTR_CLASS == CLS_BRANCH) && !short_fit_w;
      // Queue state, odd addresses and a byte-wide bus add cycles
      // this block cannot see; it flags the possibility for the last two only
      exceed_d = byte_q || ODD_OPERAND_ADDR;
    end
  end

  // Output registers
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      valid_q  <= 1'b0;
      len_q    <= {LEN_W{1'b0}};
      cyc_q    <= {CYC_W{1'b0}};
      acc_b_q  <= 1'b0;
      long_q   <= 1'b0;
      exceed_q <= 1'b0;
    end else begin
      valid_q  <= valid_d;
      len_q    <= len_d;
      cyc_q    <= cyc_d;
      acc_b_q  <= acc_b_d;
      long_q   <= long_d;
      exceed_q <= exceed_d;
    end
  end

  assign OUT_VALID      = valid_q;
  assign INSTR_LEN      = len_q;
  assign INSTR_CYC      = cyc_q;
  assign ACC_B_SEL      = acc_b_q;
  assign BRANCH_LONG    = long_q;
  assign CYC_MAY_EXCEED = exceed_q;

endmodule

// ### tb/ilt_checker_sva.sv
/*
  Port-level checker for the instruction length and timing calculator.
  Assumes ilt_pkg is compiled first; bound to the top module below.
*/
`timescale 1ns/1ps
module ilt_checker
  import ilt_pkg::*;
(
  input wire logic               CLK,
  input wire logic               ARST_N,
  input wire logic               REQ_VALID,
  input wire instr_class_t       INSTR_CLASS,
  input wire logic [LEN_W-1:0]   LISTED_LEN,
  input wire logic [CYC_W-1:0]   LISTED_CYC,
  input wire logic               OPCODE_LOWER_ROW,
  input wire logic               USES_DIRECT_PAGE,
  input wire logic [7:0]         DIRECT_PAGE_BASE_LOW,
  input wire logic               M_FLAG,
  input wire logic               X_FLAG,
  input wire logic               BRANCH_TAKEN,
  input wire logic [15:0]        BRANCH_DISP,
  input wire logic               ODD_OPERAND_ADDR,
  input wire logic               OUT_VALID,
  input wire logic [LEN_W-1:0]   INSTR_LEN,
  input wire logic [CYC_W-1:0]   INSTR_CYC,
  input wire logic               ACC_B_SEL,
  input wire logic               BRANCH_LONG,
  input wire logic               CYC_MAY_EXCEED
);
  // Expected figures, worked out from the request inputs
  wire logic grow = (INSTR_CLASS == CLS_IMM_M && !M_FLAG) ||
    (INSTR_CLASS == CLS_IMM_X && !X_FLAG) ||
    (INSTR_CLASS == CLS_MDEP && !M_FLAG);
  wire logic dp_add = USES_DIRECT_PAGE && (DIRECT_PAGE_BASE_LOW != 8'h00);
  // Short form only if bits 15..7 are a pure sign extension
  wire logic far = (BRANCH_DISP[15:7] != 9'h000) &&
    (BRANCH_DISP[15:7] != 9'h1FF);
  wire logic [CYC_W-1:0] plain_cyc = LISTED_CYC + {19'h00000, dp_add};
  wire logic [CYC_W-1:0] br_cyc = plain_cyc +
    (BRANCH_TAKEN ? TAKEN_EXTRA : 20'h00000);
  wire logic [LEN_W-1:0] len_exp = LISTED_LEN + (grow ? LEN_EXTRA : 4'h0);

  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  a_valid_follows_req: assert property (REQ_VALID |=> OUT_VALID)
    else $error("result strobe missing");
  a_no_stray_valid: assert property (!REQ_VALID |=> !OUT_VALID)
    else $error("result strobe without request");
  a_len_total: assert property (REQ_VALID |=> INSTR_LEN == $past(len_exp))
    else $error("length wrong");
  a_acc_row: assert property (REQ_VALID |=> ACC_B_SEL == $past(OPCODE_LOWER_ROW))
    else $error("accumulator select wrong");
  a_branch_form: assert property (REQ_VALID |=>
    BRANCH_LONG == $past(INSTR_CLASS == CLS_BRANCH && far))
    else $error("branch form wrong");
  a_branch_cycles: assert property (REQ_VALID && INSTR_CLASS == CLS_BRANCH
    |=> INSTR_CYC == $past(br_cyc))
    else $error("branch cycles wrong");
  a_dp_cycles: assert property (REQ_VALID && INSTR_CLASS == CLS_PLAIN
    |=> INSTR_CYC == $past(plain_cyc))
    else $error("direct page cycles wrong");
  a_data_hold: assert property (!REQ_VALID |=>
    $stable(INSTR_LEN) && $stable(INSTR_CYC))
    else $error("result changed without request");
  a_odd_exceed: assert property (REQ_VALID && ODD_OPERAND_ADDR
    |=> CYC_MAY_EXCEED)
    else $error("exceed flag missing");
endmodule

bind cpu_instruction_length_timing ilt_checker chk_u (.CLK, .ARST_N,
  .REQ_VALID, .INSTR_CLASS, .LISTED_LEN, .LISTED_CYC, .OPCODE_LOWER_ROW,
  .USES_DIRECT_PAGE, .DIRECT_PAGE_BASE_LOW, .M_FLAG, .X_FLAG,
  .BRANCH_TAKEN, .BRANCH_DISP, .ODD_OPERAND_ADDR, .OUT_VALID, .INSTR_LEN,
  .INSTR_CYC, .ACC_B_SEL, .BRANCH_LONG, .CYC_MAY_EXCEED);

// ### tb/tb.sv
/*
  Self-checking bench for the instruction length and timing calculator.
  Assumes ilt_pkg and the core files are compiled first.
*/
`timescale 1ns/1ps
module tb
  import ilt_pkg::*;
;
  logic         clk, arst_n, req, row, udp, mf, xf, tkn, wide, odd, pin;
  instr_class_t cls;            // Instruction class under test
  logic [3:0]   llen, ilen;     // Listed and produced length
  logic [19:0]  lcyc, icyc;     // Listed and produced cycles
  logic [7:0]   dpl, rl;        // Direct page low byte, register list
  logic [15:0]  disp, cnt;      // Displacement, transfer count
  logic         ov, accb, blong, exc;
  int           n_errors, checked;
  logic [15:0]  dsp [4] = '{16'h007F, 16'h0080, 16'hFF80, 16'hFF7F};
  logic [7:0]   rls [4] = '{8'hFF, 8'h60, 8'h10, 8'h00};
  logic [19:0]  psh [4] = '{20'h0001A, 20'h0000E, 20'h0000E, 20'h0000C};
  logic [19:0]  pul [4] = '{20'h00024, 20'h00011, 20'h00012, 20'h0000E};

  cpu_instruction_length_timing dut_u (.CLK(clk), .ARST_N(arst_n),
    .REQ_VALID(req), .INSTR_CLASS(cls), .LISTED_LEN(llen),
    .LISTED_CYC(lcyc), .OPCODE_LOWER_ROW(row), .USES_DIRECT_PAGE(udp),
    .DIRECT_PAGE_BASE_LOW(dpl), .M_FLAG(mf), .X_FLAG(xf),
    .BRANCH_TAKEN(tkn), .BRANCH_DISP(disp), .REG_LIST(rl),
    .XFER_COUNT(cnt), .WIDE_OPERATION(wide), .ODD_OPERAND_ADDR(odd),
    .BUS_BYTE_PIN(pin), .OUT_VALID(ov), .INSTR_LEN(ilen),
    .INSTR_CYC(icyc), .ACC_B_SEL(accb), .BRANCH_LONG(blong),
    .CYC_MAY_EXCEED(exc));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // One comparison, counted; case inequality so X never matches
  task automatic chk(input string nm, input logic [19:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One request; result is read the cycle after, then checked for holding
  task automatic ask(input instr_class_t c, input logic [3:0] l,
                     input logic [19:0] y, input logic [3:0] el,
                     input logic [19:0] ec);
    cls = c;
    llen = l;
    lcyc = y;
    req = 1'b1;
    // The edge that takes the request also launches the result
    @(posedge clk);
    #2 req = 1'b0;
    chk("valid", ov, 1'b1);
    chk("len", ilen, el);
    chk("cyc", icyc, ec);
    @(posedge clk);
    #2;
    chk("valid low", ov, 1'b0);
    chk("cyc hold", icyc, ec);
  endtask

  // Verdict in one place, for both normal end and watchdog
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog: the sequence needs a few hundred cycles at most
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    summarize();
  end

  // Main sequence
  initial begin
    {req, row, udp, mf, xf, tkn, wide, odd, pin} = '0;
    {llen, lcyc, dpl, rl, disp, cnt} = '0;
    cls = CLS_PLAIN;
    n_errors = 0;
    checked = 0;
    arst_n = 1'b0;
    repeat (12) @(posedge clk);
    #2 arst_n = 1'b1;
    // Internal reset lifts two edges later; two spare edges for safety
    repeat (4) @(posedge clk);
    #2;
    ask(CLS_PLAIN, 4'h2, 20'h00003, 4'h2, 20'h00003);
    udp = 1'b1;
    dpl = 8'h01;
    row = 1'b1;
    ask(CLS_PLAIN, 4'h2, 20'h00003, 4'h2, 20'h00004);
    chk("acc b", accb, 1'b1);
    rl = 8'h00;
    ask(CLS_PUSH, 4'h2, 20'h00099, 4'h2, 20'h0000D);
    {udp, dpl, row} = '0;
    ask(CLS_PLAIN, 4'h2, 20'h00003, 4'h2, 20'h00003);
    chk("acc a", accb, 1'b0);
    xf = 1'b1;
    ask(CLS_IMM_M, 4'h2, 20'h00002, 4'h3, 20'h00002);
    ask(CLS_IMM_X, 4'h2, 20'h00002, 4'h2, 20'h00002);
    ask(CLS_MDEP, 4'h3, 20'h00004, 4'h4, 20'h00004);
    {mf, xf} = 2'b10;
    ask(CLS_IMM_M, 4'h2, 20'h00002, 4'h2, 20'h00002);
    ask(CLS_IMM_X, 4'h2, 20'h00002, 4'h3, 20'h00002);
    ask(CLS_MDEP, 4'h3, 20'h00004, 4'h3, 20'h00004);
    // Displacement edges: long form on odd entries, taken on upper two
    for (int k = 0; k < 4; k++) begin
      disp = dsp[k];
      tkn = k[1];
      ask(CLS_BRANCH, 4'h2, 20'h00004, 4'h2,
          k[1] ? 20'h00006 : 20'h00004);
      chk("long", blong, {19'h00000, k[0]});
    end
    ask(CLS_PLAIN, 4'h1, 20'h00002, 4'h1, 20'h00002);
    chk("long other", blong, 1'b0);
    for (int k = 0; k < 4; k++) begin
      rl = rls[k];
      ask(CLS_PUSH, 4'h1, 20'h00099, 4'h1, psh[k]);
      ask(CLS_PULL, 4'h1, 20'h00099, 4'h1, pul[k]);
    end
    cnt = 16'h0001;
    ask(CLS_BLK1, 4'h3, 20'h00055, 4'h3, 20'h0000B);
    cnt = 16'hFFFF;
    ask(CLS_BLK1, 4'h3, 20'h00055, 4'h3, 20'h38004);
    ask(CLS_BLK2, 4'h3, 20'h00055, 4'h3, 20'h38007);
    cnt = 16'h0003;
    ask(CLS_BLK2, 4'h3, 20'h00055, 4'h3, 20'h00015);
    cnt = 16'h0004;
    ask(CLS_BLK1, 4'h3, 20'h00055, 4'h3, 20'h00055);
    ask(CLS_DIV, 4'h2, 20'h00019, 4'h2, 20'h00019);
    wide = 1'b1;
    ask(CLS_DIV, 4'h2, 20'h00019, 4'h2, 20'h00029);
    ask(CLS_MUL, 4'h2, 20'h00010, 4'h2, 20'h00018);
    odd = 1'b1;
    ask(CLS_PLAIN, 4'h1, 20'h00002, 4'h1, 20'h00002);
    chk("exceed odd", exc, 1'b1);
    odd = 1'b0;
    ask(CLS_PLAIN, 4'h1, 20'h00002, 4'h1, 20'h00002);
    chk("exceed none", exc, 1'b0);
    // Byte pin passes a two-flop synchroniser before it counts
    pin = 1'b1;
    repeat (3) @(posedge clk);
    #2;
    ask(CLS_PLAIN, 4'h1, 20'h00002, 4'h1, 20'h00002);
    chk("exceed pin", exc, 1'b1);
    summarize();
  end
endmodule
